/* File: rtl/ocs_selector.sv */
`timescale 1ns/100ps
`default_nettype none
// Operation
// R01 - Two select settings, open-collector and relay, each code 0 to 19.
// R02 - Code 17 drives the output from the fault mask.
// R03 - Mask bit0 low-voltage trip, bit1 other trip, bit2 restart configured.
// R04 - Code 0: command and output frequency within half bandwidth.
// R05 - Bandwidth 0 to 400 Hz, default 10 Hz, refused above max frequency.
// R06 - Code 1: command equals level and code 0 condition holds.
// R07 - Code 2: level and running frequency within half bandwidth.
// R08 - Code 3: accel at or above level, decel above level minus half band.
// R09 - Code 4: inverse of code 3 condition, normally closed.
// R10 - Code 8: over-voltage trip.
// R11 - Code 9: low-voltage trip.
// R12 - Code 10: heatsink overheat flag.
// R13 - Code 11: analog or serial command loss.
// R14 - Code 12: run command present and drive producing voltage.
// R15 - Code 13: stopped with no run command.
// R16 - Code 14: running at constant speed.
// R17 - Code 16: normal operation waiting for external run command.
// R18 - Code 18: fan trip alarm when fan mode keeps running.
// R19 - Code 19: external brake signal when brake use configured.
// R20 - Keypad error routing: bit0 open collector, bit1 relay, default 0.
// R21 - Keypad error drives outputs only after persisting for a set time.
// R22 - Outputs registered each clock, unsigned 0.01 Hz, cleared on reset; the code resets relay_contact_nc to 1.
module ocs_selector #(
    parameter int FREQ_W     = ocs_pkg::FREQ_W,
    parameter int KP_ERR_CYC = ocs_pkg::KP_ERR_CYCLES
) (
    // Clock and reset
    input  wire logic              clock,
    input  wire logic              rst_n,
    // Output select settings
    input  wire logic [4:0]        oc_output_select,
    input  wire logic [4:0]        relay_output_select,
    input  wire logic [2:0]        fault_mask,
    input  wire logic [1:0]        keypad_err_routing,
    // Frequency settings, 0.01 Hz
    input  wire logic [FREQ_W-1:0] detect_level,
    input  wire logic [FREQ_W-1:0] detect_bandwidth,
    input  wire logic [FREQ_W-1:0] max_frequency,
    // Frequencies from the drive, 0.01 Hz
    input  wire logic [FREQ_W-1:0] cmd_frequency,
    input  wire logic [FREQ_W-1:0] run_frequency,
    // Drive state
    input  wire logic              accelerating,
    input  wire logic              decelerating,
    input  wire logic              run_cmd,
    input  wire logic              output_active,
    input  wire logic              wait_run,
    input  wire logic              auto_restart_set,
    input  wire logic              fan_trip_mode,
    input  wire logic              brake_enable,
    // Status flags from the drive
    input  wire logic              motor_overload_warn,
    input  wire logic              drive_overload_warn,
    input  wire logic              stall_active,
    input  wire logic              over_volt_trip,
    input  wire logic              low_volt_trip,
    input  wire logic              other_trip,
    input  wire logic              heatsink_overheat,
    input  wire logic              analog_cmd_loss,
    input  wire logic              serial_cmd_loss,
    input  wire logic              speed_search,
    input  wire logic              fan_fault,
    input  wire logic              brake_signal,
    // Keypad link error, from outside the clock domain
    input  wire logic              keypad_link_err,
    // Outputs
    output var  logic              open_collector_out,
    output var  logic              relay_contact_no,
    output var  logic              relay_contact_nc,
    output var  logic              keypad_err_display,
    output var  logic              bandwidth_rejected
);

    typedef struct packed {
        logic [FREQ_W-1:0] bw;
        logic              hyst;
        logic              oc;
        logic              relay;
        logic              relay_nc;
        logic              kp_disp;
        logic              bw_rej;
    } ocs_state_s;

    ocs_state_s st_reg;
    ocs_state_s st_next;

    logic kp_err_sync;
    logic kp_err_held;

    initial begin
        if (FREQ_W < 16)
            $error("ocs_selector: FREQ_W too small for 400 Hz");
        if (KP_ERR_CYC < 1)
            $error("ocs_selector: KP_ERR_CYC must be at least 1");
    end

    // ****************************************
    // Helpers
    // ****************************************
    function automatic logic [FREQ_W-1:0] abs_diff(
        input logic [FREQ_W-1:0] a,
        input logic [FREQ_W-1:0] b
    );
        abs_diff = (a >= b) ? a - b : b - a;
    endfunction

    // Half bandwidth drops the odd 0.01 Hz, so the window is never wider
    function automatic logic within_half(
        input logic [FREQ_W-1:0] a,
        input logic [FREQ_W-1:0] b,
        input logic [FREQ_W-1:0] bw
    );
        within_half = abs_diff(a, b) <= (bw >> 1);
    endfunction

    // ****************************************
    // Keypad error path
    // ****************************************
    ocs_sync #(
        .WIDTH (1)
    ) u_kp_sync (
        .clock    (clock),
        .rst_n    (rst_n),
        .async_in (keypad_link_err),
        .sync_out (kp_err_sync)
    );

    ocs_persist #(
        .CYCLES (KP_ERR_CYC)
    ) u_kp_persist (
        .clock (clock),
        .rst_n (rst_n),
        .cond  (kp_err_sync),
        .held  (kp_err_held)          // R21
    );

    // ****************************************
    // Condition select
    // ****************************************
    logic              c_match_cmd;
    logic              c_match_level;
    logic              c_band_level;
    logic              c_fault;
    logic [FREQ_W-1:0] lvl_low;
    logic [19:0]       cond_vec;

    function automatic logic pick(
        input logic [4:0]  sel,
        input logic [19:0] vec
    );
        pick = (sel <= ocs_pkg::SEL_MAX) ? vec[sel] : 1'b0;   // R01
    endfunction

    always_comb begin
        st_next = st_reg;
        lvl_low = (detect_level > (st_reg.bw >> 1)) ?
                  detect_level - (st_reg.bw >> 1) : '0;

        // Bandwidth setting accepted only within range and max frequency
        if (detect_bandwidth > max_frequency ||
            detect_bandwidth > FREQ_W'(ocs_pkg::BW_LIMIT)) begin
            st_next.bw_rej = 1'b1;    // R05
        end else begin
            st_next.bw     = detect_bandwidth;    // R05
            st_next.bw_rej = 1'b0;
        end

        c_match_cmd   = within_half(cmd_frequency, run_frequency,
                                    st_reg.bw);                      // R04
        c_match_level = (cmd_frequency == detect_level) && c_match_cmd; // R06
        c_band_level  = within_half(detect_level, run_frequency,
                                    st_reg.bw);                      // R07

        // Hysteresis: set at level, held while decelerating above level minus half band
        if (run_frequency >= detect_level)
            st_next.hyst = 1'b1;      // R08
        else if (!(decelerating && st_reg.hyst && run_frequency > lvl_low))
            st_next.hyst = 1'b0;      // R08

        c_fault = (fault_mask[ocs_pkg::FM_LOW_VOLT]   && low_volt_trip) ||
                  (fault_mask[ocs_pkg::FM_OTHER_TRIP] && other_trip)    ||
                  (fault_mask[ocs_pkg::FM_RESTART] && auto_restart_set); // R03

        cond_vec = '0;
        cond_vec[ocs_pkg::SEL_FREQ_MATCH_CMD]   = c_match_cmd;
        cond_vec[ocs_pkg::SEL_FREQ_MATCH_LEVEL] = c_match_level;
        cond_vec[ocs_pkg::SEL_FREQ_BAND_LEVEL]  = c_band_level;
        cond_vec[ocs_pkg::SEL_FREQ_HYST]        = st_reg.hyst;       // R08
        cond_vec[ocs_pkg::SEL_FREQ_HYST_INV]    = !st_reg.hyst;      // R09
        cond_vec[ocs_pkg::SEL_MOTOR_OVERLOAD]   = motor_overload_warn;
        cond_vec[ocs_pkg::SEL_DRIVE_OVERLOAD]   = drive_overload_warn;
        cond_vec[ocs_pkg::SEL_STALL]            = stall_active;
        cond_vec[ocs_pkg::SEL_OVER_VOLT]        = over_volt_trip;    // R10
        cond_vec[ocs_pkg::SEL_LOW_VOLT]         = low_volt_trip;     // R11
        cond_vec[ocs_pkg::SEL_OVERHEAT]         = heatsink_overheat; // R12
        cond_vec[ocs_pkg::SEL_CMD_LOSS]         =
            analog_cmd_loss || serial_cmd_loss;                      // R13
        cond_vec[ocs_pkg::SEL_RUNNING]          =
            run_cmd && output_active;                                // R14
        cond_vec[ocs_pkg::SEL_STOPPED]          =
            !run_cmd && !output_active;                              // R15
        cond_vec[ocs_pkg::SEL_CONST_SPEED]      = output_active &&
            !accelerating && !decelerating;                          // R16
        cond_vec[ocs_pkg::SEL_SPEED_SEARCH]     = speed_search;
        cond_vec[ocs_pkg::SEL_WAIT_RUN]         = wait_run && !run_cmd; // R17
        cond_vec[ocs_pkg::SEL_FAULT]            = c_fault;           // R02
        cond_vec[ocs_pkg::SEL_FAN_ALARM]        = fan_fault &&
            (fan_trip_mode == 1'(ocs_pkg::FAN_KEEP_RUN));            // R18
        cond_vec[ocs_pkg::SEL_BRAKE]            =
            brake_enable && brake_signal;                            // R19

        // Keypad error is ORed onto the routed outputs
        st_next.oc      = pick(oc_output_select, cond_vec) ||
            (kp_err_held && keypad_err_routing[ocs_pkg::KR_OC]);     // R20
        st_next.relay   = pick(relay_output_select, cond_vec) ||
            (kp_err_held && keypad_err_routing[ocs_pkg::KR_RELAY]);  // R20
        st_next.relay_nc = !st_next.relay;
        st_next.kp_disp = kp_err_held;                               // R21
    end

    // Bandwidth register starts at its default, outputs start off except the NC contact, which starts at 1
    always_ff @(posedge clock or negedge rst_n) begin
        if (!rst_n) begin
            st_reg.bw      <= FREQ_W'(ocs_pkg::BW_DEFAULT);
            st_reg.hyst    <= 1'b0;
            st_reg.oc      <= 1'b0;   // R22
            st_reg.relay   <= 1'b0;   // R22
            st_reg.relay_nc <= 1'b1;  // R22
            st_reg.kp_disp <= 1'b0;
            st_reg.bw_rej  <= 1'b0;
        end else begin
            st_reg <= st_next;        // R22
        end
    end

    // ****************************************
    // Outputs
    // ****************************************
    // Contact pair flops load together so both never close at once
    assign open_collector_out = st_reg.oc;
    assign relay_contact_no   = st_reg.relay;
    assign relay_contact_nc   = st_reg.relay_nc;
    assign keypad_err_display = st_reg.kp_disp;
    assign bandwidth_rejected = st_reg.bw_rej;

endmodule
`default_nettype wire

/* File: rtl/ocs_pkg.sv */
package ocs_pkg;

    // ****************************************
    // Widths
    // ****************************************
    localparam int FREQ_W = 16;
    localparam int SEL_W  = 5;

    // ****************************************
    // Select codes
    // ****************************************
    localparam logic [4:0] SEL_FREQ_MATCH_CMD   = 5'h00;
    localparam logic [4:0] SEL_FREQ_MATCH_LEVEL = 5'h01;
    localparam logic [4:0] SEL_FREQ_BAND_LEVEL  = 5'h02;
    localparam logic [4:0] SEL_FREQ_HYST        = 5'h03;
    localparam logic [4:0] SEL_FREQ_HYST_INV    = 5'h04;
    localparam logic [4:0] SEL_MOTOR_OVERLOAD   = 5'h05;
    localparam logic [4:0] SEL_DRIVE_OVERLOAD   = 5'h06;
    localparam logic [4:0] SEL_STALL            = 5'h07;
    localparam logic [4:0] SEL_OVER_VOLT        = 5'h08;
    localparam logic [4:0] SEL_LOW_VOLT         = 5'h09;
    localparam logic [4:0] SEL_OVERHEAT         = 5'h0A;
    localparam logic [4:0] SEL_CMD_LOSS         = 5'h0B;
    localparam logic [4:0] SEL_RUNNING          = 5'h0C;
    localparam logic [4:0] SEL_STOPPED          = 5'h0D;
    localparam logic [4:0] SEL_CONST_SPEED      = 5'h0E;
    localparam logic [4:0] SEL_SPEED_SEARCH     = 5'h0F;
    localparam logic [4:0] SEL_WAIT_RUN         = 5'h10;
    localparam logic [4:0] SEL_FAULT            = 5'h11;
    localparam logic [4:0] SEL_FAN_ALARM        = 5'h12;
    localparam logic [4:0] SEL_BRAKE            = 5'h13;
    localparam logic [4:0] SEL_MAX              = 5'h13;

    // ****************************************
    // Fault mask fields
    // ****************************************
    localparam int FM_LOW_VOLT   = 0;
    localparam int FM_OTHER_TRIP = 1;
    localparam int FM_RESTART    = 2;

    // ****************************************
    // Keypad error routing fields
    // ****************************************
    localparam int KR_OC    = 0;
    localparam int KR_RELAY = 1;

    // ****************************************
    // Defaults and bandwidth limit, in 0.01 Hz
    // ****************************************
    localparam logic [15:0] BW_DEFAULT    = 16'h03E8;
    localparam logic [15:0] LEVEL_DEFAULT = 16'h0BB8;
    localparam logic [15:0] BW_LIMIT      = 16'h9C40;

    // ****************************************
    // Keypad error persistence time, fan mode code
    // ****************************************
    localparam int CLK_HZ        = 25_000_000;
    localparam int KP_ERR_MS     = 1000;
    localparam int KP_ERR_CYCLES = (CLK_HZ / 1000) * KP_ERR_MS;
    localparam int FAN_KEEP_RUN  = 0;

endpackage

/* File: rtl/ocs_sync.sv */
`timescale 1ns/100ps
`default_nettype none
module ocs_sync #(
    parameter int WIDTH = 1
) (
    // Clock and reset
    input  wire logic             clock,
    input  wire logic             rst_n,
    // Data
    input  wire logic [WIDTH-1:0] async_in,
    output var  logic [WIDTH-1:0] sync_out
);

    typedef struct packed {
        logic [WIDTH-1:0] s1;
        logic [WIDTH-1:0] s2;
        logic [WIDTH-1:0] s3;
        logic [WIDTH-1:0] q;
    } ocs_sync_s;

    ocs_sync_s st_reg;
    ocs_sync_s st_next;

    initial begin
        if (WIDTH < 1)
            $error("ocs_sync: WIDTH must be at least 1");
    end

    // Value counts only once the last two stages agree
    always_comb begin
        st_next    = st_reg;
        st_next.s1 = async_in;
        st_next.s2 = st_reg.s1;
        st_next.s3 = st_reg.s2;
        for (int i = 0; i < WIDTH; i++) begin
            if (st_reg.s2[i] == st_reg.s3[i])
                st_next.q[i] = st_reg.s3[i];
        end
    end

    always_ff @(posedge clock or negedge rst_n) begin
        if (!rst_n)
            st_reg <= '0;
        else
            st_reg <= st_next;
    end

    assign sync_out = st_reg.q;

endmodule
`default_nettype wire

/* File: rtl/ocs_persist.sv */
`timescale 1ns/100ps
`default_nettype none
module ocs_persist #(
    parameter int CYCLES = 25_000_000
) (
    // Clock and reset
    input  wire logic clock,
    input  wire logic rst_n,
    // Condition and result
    input  wire logic cond,
    output var  logic held
);

    localparam int CW = $clog2(CYCLES + 1);

    typedef struct packed {
        logic [CW-1:0] cnt;
        logic          held;
    } ocs_persist_s;

    ocs_persist_s st_reg;
    ocs_persist_s st_next;

    initial begin
        if (CYCLES < 1)
            $error("ocs_persist: CYCLES must be at least 1");
    end

    // Any break in the condition restarts the wait
    always_comb begin
        st_next = st_reg;
        if (!cond) begin
            st_next.cnt  = '0;
            st_next.held = 1'b0;
        end else if (st_reg.cnt == CW'(CYCLES - 1)) begin
            st_next.held = 1'b1;
        end else begin
            st_next.cnt = st_reg.cnt + CW'(1);
        end
    end

    always_ff @(posedge clock or negedge rst_n) begin
        if (!rst_n)
            st_reg <= '0;
        else
            st_reg <= st_next;
    end

    assign held = st_reg.held;

endmodule
`default_nettype wire

/* File: test/ocs_selector_chk.sv */
`timescale 1ns/100ps
`default_nettype none
// ********************************
// Port-level checks
// ********************************
module ocs_selector_chk #(
    parameter int KP_ERR_CYC = 20
) (
    // Clock and reset
    input wire logic        clock,
    input wire logic        rst_n,
    // Settings
    input wire logic [4:0]  oc_output_select,
    input wire logic [4:0]  relay_output_select,
    input wire logic [2:0]  fault_mask,
    input wire logic [1:0]  keypad_err_routing,
    input wire logic [15:0] detect_bandwidth,
    input wire logic [15:0] max_frequency,
    // Drive flags
    input wire logic        auto_restart_set,
    input wire logic        over_volt_trip,
    input wire logic        low_volt_trip,
    input wire logic        other_trip,
    input wire logic        keypad_link_err,
    // Outputs
    input wire logic        open_collector_out,
    input wire logic        relay_contact_no,
    input wire logic        relay_contact_nc,
    input wire logic        keypad_err_display,
    input wire logic        bandwidth_rejected
);
    logic      armed;
    int        err_cnt;
    wire logic bw_bad;
    // Limit is 400.00 Hz in 0.01 Hz steps
    assign bw_bad = detect_bandwidth > max_frequency ||
                    detect_bandwidth > 16'h9C40;
    // First edge after reset would see reset-time inputs, so skip it
    always_ff @(posedge clock or negedge rst_n) begin
        if (!rst_n) begin
            armed   <= 1'b0;
            err_cnt <= 0;
        end else begin
            armed   <= 1'b1;
            err_cnt <= keypad_link_err ? err_cnt + 1 : 0;
        end
    end
    default clocking cb @(posedge clock); endclocking
    default disable iff (!rst_n);
    sequence s_kp_oc;
        keypad_err_routing[0] && keypad_err_display ##1 keypad_err_display;
    endsequence
    sequence s_kp_rl;
        keypad_err_routing[1] && keypad_err_display ##1 keypad_err_display;
    endsequence
    a_nc_inverse: assert property (
        relay_contact_nc == !relay_contact_no)
        else $error("nc contact not inverse of no contact");
    a_ovt_pass: assert property (
        armed && $past(oc_output_select) == ocs_pkg::SEL_OVER_VOLT &&
        !$past(keypad_err_routing[0])
        |-> open_collector_out == $past(over_volt_trip))
        else $error("code 8 output wrong");
    a_sel_range: assert property (
        armed && $past(oc_output_select) > ocs_pkg::SEL_MAX &&
        !$past(keypad_err_routing[0]) |-> !open_collector_out)
        else $error("unused code drives output");
    a_fault_mask: assert property (
        armed && $past(relay_output_select) == ocs_pkg::SEL_FAULT &&
        !$past(keypad_err_routing[1]) |-> relay_contact_no ==
        |($past(fault_mask) & {$past(auto_restart_set),
        $past(other_trip), $past(low_volt_trip)}))
        else $error("fault mask output wrong");
    a_bw_reject: assert property (
        armed |-> bandwidth_rejected == $past(bw_bad))
        else $error("bandwidth reject flag wrong");
    a_kp_early: assert property (
        $rose(keypad_err_display) |-> err_cnt >= KP_ERR_CYC)
        else $error("keypad error shown too early");
    a_kp_late: assert property (
        err_cnt == KP_ERR_CYC + 8 |-> keypad_err_display)
        else $error("keypad error not shown");
    a_kp_oc: assert property (s_kp_oc |-> open_collector_out)
        else $error("keypad error not on open collector");
    a_kp_relay: assert property (s_kp_rl |-> relay_contact_no)
        else $error("keypad error not on relay");
endmodule
bind ocs_selector ocs_selector_chk #(.KP_ERR_CYC(KP_ERR_CYC)) chk_u (
    .clock, .rst_n, .oc_output_select, .relay_output_select, .fault_mask,
    .keypad_err_routing, .detect_bandwidth, .max_frequency,
    .auto_restart_set, .over_volt_trip, .low_volt_trip, .other_trip,
    .keypad_link_err, .open_collector_out, .relay_contact_no,
    .relay_contact_nc, .keypad_err_display, .bandwidth_rejected
);
`default_nettype wire

/* File: test/ocs_load.sv */
`timescale 1ns/100ps
`default_nettype none
// ********************************
// External output circuits
// ********************************
module ocs_load (
    // Driven side
    input  wire logic open_collector_out,
    input  wire logic relay_contact_no,
    input  wire logic relay_contact_nc,
    // Load side
    output var  logic oc_line,
    output var  logic com_a,
    output var  logic com_b
);
    // Pull-up load: line is low while the transistor conducts
    assign oc_line = !open_collector_out;
    assign com_a = relay_contact_no;
    assign com_b = relay_contact_nc;
endmodule
`default_nettype wire

/* File: test/ocs_selector_test.sv */
`timescale 1ns/100ps
`default_nettype none
module ocs_selector_test;
    typedef struct packed {
        logic [4:0]  s;
        logic [15:0] c;
        logic [15:0] r;
        logic [19:0] b;
        logic [2:0]  m;
        logic        e;
    } ocs_row_s;
    localparam logic [15:0] Z = 16'h0000;
    logic        clock, rst_n, kp_err;
    logic [4:0]  sel_oc, sel_rl;
    logic [2:0]  fmask;
    logic [1:0]  route;
    logic [15:0] lvl, bw, mx, cmd, run;
    logic [19:0] b;
    wire logic   oc, no, nc, disp, rej, oc_line, com_a, com_b;
    int          bad_count, total_checks, k;
    ocs_row_s    rows [35] = '{
        '{5'h00,16'h03E8,16'h05DC,20'h00000,3'h0,1'h1},
        '{5'h00,16'h03E8,16'h05DD,20'h00000,3'h0,1'h0},
        '{5'h01,16'h0BB8,16'h0BB8,20'h00000,3'h0,1'h1},
        '{5'h01,16'h0BB7,16'h0BB7,20'h00000,3'h0,1'h0},
        '{5'h02,Z,16'h09C4,20'h00000,3'h0,1'h1},
        '{5'h02,Z,16'h0DAD,20'h00000,3'h0,1'h0},
        '{5'h05,Z,Z,20'h00100,3'h0,1'h1},
        '{5'h06,Z,Z,20'h00200,3'h0,1'h1},
        '{5'h07,Z,Z,20'h00400,3'h0,1'h1},
        '{5'h08,Z,Z,20'h00800,3'h0,1'h1},
        '{5'h08,Z,Z,20'h01000,3'h0,1'h0},
        '{5'h09,Z,Z,20'h01000,3'h0,1'h1},
        '{5'h0A,Z,Z,20'h04000,3'h0,1'h1},
        '{5'h0B,Z,Z,20'h08000,3'h0,1'h1},
        '{5'h0B,Z,Z,20'h10000,3'h0,1'h1},
        '{5'h0C,Z,Z,20'h0000C,3'h0,1'h1},
        '{5'h0C,Z,Z,20'h00004,3'h0,1'h0},
        '{5'h0D,Z,Z,20'h00000,3'h0,1'h1},
        '{5'h0D,Z,Z,20'h00004,3'h0,1'h0},
        '{5'h0E,Z,Z,20'h00008,3'h0,1'h1},
        '{5'h0E,Z,Z,20'h00009,3'h0,1'h0},
        '{5'h0F,Z,Z,20'h20000,3'h0,1'h1},
        '{5'h10,Z,Z,20'h00010,3'h0,1'h1},
        '{5'h10,Z,Z,20'h00014,3'h0,1'h0},
        '{5'h11,Z,Z,20'h01000,3'h2,1'h0},
        '{5'h11,Z,Z,20'h02000,3'h2,1'h1},
        '{5'h11,Z,Z,20'h01000,3'h1,1'h1},
        '{5'h11,Z,Z,20'h00020,3'h4,1'h1},
        '{5'h11,Z,Z,20'h00020,3'h3,1'h0},
        '{5'h12,Z,Z,20'h40000,3'h0,1'h1},
        '{5'h12,Z,Z,20'h40040,3'h0,1'h0},
        '{5'h13,Z,Z,20'h80080,3'h0,1'h1},
        '{5'h13,Z,Z,20'h80000,3'h0,1'h0},
        '{5'h14,Z,Z,20'hFFFFF,3'h0,1'h0},
        '{5'h1F,Z,Z,20'hFFFFF,3'h0,1'h0}
    };
    ocs_selector #(.KP_ERR_CYC(20)) dut_u (
        .clock(clock), .rst_n(rst_n), .oc_output_select(sel_oc),
        .relay_output_select(sel_rl), .fault_mask(fmask),
        .keypad_err_routing(route), .detect_level(lvl),
        .detect_bandwidth(bw), .max_frequency(mx), .cmd_frequency(cmd),
        .run_frequency(run), .accelerating(b[0]), .decelerating(b[1]),
        .run_cmd(b[2]), .output_active(b[3]), .wait_run(b[4]),
        .auto_restart_set(b[5]), .fan_trip_mode(b[6]),
        .brake_enable(b[7]), .motor_overload_warn(b[8]),
        .drive_overload_warn(b[9]), .stall_active(b[10]),
        .over_volt_trip(b[11]), .low_volt_trip(b[12]), .other_trip(b[13]),
        .heatsink_overheat(b[14]), .analog_cmd_loss(b[15]),
        .serial_cmd_loss(b[16]), .speed_search(b[17]), .fan_fault(b[18]),
        .brake_signal(b[19]), .keypad_link_err(kp_err),
        .open_collector_out(oc), .relay_contact_no(no),
        .relay_contact_nc(nc), .keypad_err_display(disp),
        .bandwidth_rejected(rej)
    );
    ocs_load load_u (
        .open_collector_out(oc), .relay_contact_no(no),
        .relay_contact_nc(nc), .oc_line(oc_line), .com_a(com_a),
        .com_b(com_b)
    );
    // ********************************
    // Helpers
    // ********************************
    task automatic chk(input logic got, input logic exp, input string w);
        total_checks++;
        if (got !== exp) begin
            bad_count++;
            $display("Error at %0t: %s got %b exp %b", $time, w, got, exp);
        end
    endtask
    // Margin over the two-edge worst case for bandwidth and hysteresis
    task automatic settle();
        repeat (4) @(posedge clock);
        #1;
    endtask
    task automatic rst_chk();
        chk(oc, 1'b0, "reset oc");
        chk(no, 1'b0, "reset no");
        chk(nc, 1'b1, "reset nc");
        chk(disp, 1'b0, "reset disp");
        chk(rej, 1'b0, "reset rej");
    endtask
    task automatic hy(input logic [15:0] r, input logic d, input logic e);
        @(posedge clock);
        run <= r;
        b <= {18'h00000, d, !d};
        settle();
        chk(oc, e, "hyst oc");
        chk(no, !e, "hyst no");
    endtask
    task automatic bwt(input logic [15:0] w, input logic [15:0] m,
                       input logic [15:0] r, input logic j, input logic e);
        @(posedge clock);
        bw <= w;
        mx <= m;
        run <= r;
        settle();
        chk(rej, j, "reject");
        chk(oc, e, "band oc");
    endtask
    task automatic conclude();
        $display("checks %0d mismatches %0d", total_checks, bad_count);
        if (bad_count == 0 && total_checks > 0) begin
            $display("RESULT: PASS");
        end else begin
            $display("RESULT: FAIL");
        end
        $finish;
    endtask
    initial begin
        clock = 1'b0;
        forever #20 clock = ~clock;
    end
    initial begin
        repeat (4000) @(posedge clock);
        bad_count++;
        $display("Error at %0t: watchdog expired", $time);
        conclude();
    end
    // ********************************
    // Tests
    // ********************************
    initial begin
        rst_n = 1'b0;
        kp_err = 1'b0;
        sel_oc = 5'h00;
        sel_rl = 5'h00;
        fmask = 3'h0;
        route = 2'h0;
        lvl = 16'h0BB8;
        bw = 16'h03E8;
        mx = 16'h1770;
        cmd = 16'h0000;
        run = 16'h0000;
        b = 20'h00000;
        repeat (6) @(posedge clock);
        #1;
        rst_chk();
        repeat (6) @(posedge clock);
        rst_n <= 1'b1;
        foreach (rows[i]) begin
            @(posedge clock);
            sel_oc <= rows[i].s;
            sel_rl <= rows[i].s;
            cmd <= rows[i].c;
            run <= rows[i].r;
            b <= rows[i].b;
            fmask <= rows[i].m;
            settle();
            chk(oc, rows[i].e, "table oc");
            chk(no, rows[i].e, "table no");
            chk(oc_line, !rows[i].e, "oc line");
            chk(com_b, !rows[i].e, "nc contact");
        end
        $display("table test done");
        @(posedge clock);
        sel_oc <= 5'h03;
        sel_rl <= 5'h04;
        hy(16'h0BB7, 1'b0, 1'b0);
        hy(16'h0BB8, 1'b0, 1'b1);
        hy(16'h09C5, 1'b1, 1'b1);
        hy(16'h09C4, 1'b1, 1'b0);
        hy(16'h0AF0, 1'b1, 1'b0);
        $display("hysteresis test done");
        @(posedge clock);
        sel_oc <= 5'h00;
        sel_rl <= 5'h00;
        cmd <= 16'h03E8;
        b <= 20'h00000;
        bwt(16'h1771, 16'h1770, 16'h05DC, 1'b1, 1'b1);
        bwt(16'h9C40, 16'hFFFF, 16'h05DC, 1'b0, 1'b1);
        bwt(16'h9C41, 16'hFFFF, 16'h05DC, 1'b1, 1'b1);
        bwt(16'h0000, 16'h1770, 16'h05DC, 1'b0, 1'b0);
        bwt(16'h0000, 16'h1770, 16'h03E8, 1'b0, 1'b1);
        bwt(16'h03E8, 16'h1770, 16'h05DC, 1'b0, 1'b1);
        $display("bandwidth test done");
        @(posedge clock);
        sel_oc <= 5'h14;
        sel_rl <= 5'h14;
        route <= 2'h1;
        kp_err <= 1'b1;
        // A short link error must not reach the outputs
        repeat (10) @(posedge clock);
        kp_err <= 1'b0;
        settle();
        chk(disp, 1'b0, "short error");
        @(posedge clock);
        kp_err <= 1'b1;
        for (k = 0; k < 60 && disp !== 1'b1; k++) begin
            @(posedge clock);
            #1;
        end
        chk(disp, 1'b1, "error shown");
        chk(k >= 20, 1'b1, "error delay");
        settle();
        chk(oc, 1'b1, "routed oc");
        chk(no, 1'b0, "unrouted relay");
        @(posedge clock);
        route <= 2'h3;
        settle();
        chk(no, 1'b1, "routed relay");
        $display("keypad test done");
        @(posedge clock);
        rst_n <= 1'b0;
        #1;
        rst_chk();
        @(posedge clock);
        rst_n <= 1'b1;
        kp_err <= 1'b0;
        bw <= 16'hFFFF;
        sel_oc <= 5'h00;
        settle();
        chk(disp, 1'b0, "after reset");
        chk(rej, 1'b1, "default reject");
        chk(oc, 1'b1, "default band");
        $display("reset test done");
        conclude();
    end
endmodule
`default_nettype wire
